// ### rtl/ptp_cfg_pkg.sv
// package for the time protocol configuration register bank
// assumes a 16-bit register port with byte addresses as printed
package ptp_cfg_pkg;
  localparam logic [11:0] DUR_HIGH_OFFSET = 12'h510;
  localparam logic [11:0] DUR_LOW_OFFSET = 12'h512;
  localparam logic [11:0] MSG_CFG_ONE_OFFSET = 12'h514;
  localparam logic [11:0] RATE_HIGH_OFFSET = 12'h50C;
  localparam logic [11:0] RATE_LOW_OFFSET = 12'h50E;
  localparam logic [15:0] DUR_RESET = 16'h0000;
  localparam logic [15:0] RATE_RESET = 16'h0000;
  localparam logic [7:0] MSG_CFG_ONE_RESET = 8'h39;
  localparam int AS_MODE_BIT = 7;
  localparam int PTP_MODE_BIT = 6;
  localparam int L2_DETECT_BIT = 5;
  localparam int IPV4_DETECT_BIT = 4;
  localparam int IPV6_DETECT_BIT = 3;
  localparam int P2P_BIT = 2;
  localparam int MASTER_BIT = 1;
  localparam int ONE_STEP_BIT = 0;
  localparam int RATE_DIR_BIT = 15;
  localparam int TEMP_ADJ_BIT = 14;
  localparam int SUBNS_WIDTH = 30;

  typedef struct packed {
    logic ptp_enable;
    logic as_mode;
    logic forward_all_to_host;
    logic header_rewrite_allowed;
    logic timestamp_insert;
    logic tod_clock_enable;
    logic timestamp_tail_tag;
    logic detect_l2;
    logic detect_ipv4;
    logic detect_ipv6;
    logic peer_to_peer;
    logic host_master;
    logic one_step;
  } ptp_mode_type;

  typedef struct packed {
    logic active;
    logic add;
    logic [SUBNS_WIDTH-1:0] step;
  } adjust_type;

  typedef enum logic [0:0] {
    ADJ_IDLE = 1'b0,
    ADJ_RUN = 1'b1
  } adj_state_type;
endpackage : ptp_cfg_pkg

// ### rtl/ptp_message_config_regs.sv
// register bank for time protocol mode and temporary rate adjustment
// assumes one 25 MHz-equivalent tick per enabled ref_clk cycle and a non-waiting master
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// RULE1: low duration word counts adjustment cycles
// RULE2: high duration word from companion register
// RULE3: adjust time each cycle while enabled
// RULE4: direction bit selects add or subtract
// RULE5: count cycles, stop at duration
// RULE6: 802.1AS bit needs protocol mode bit
// RULE7: 802.1AS forwards all messages to host
// RULE8: 802.1AS leaves message headers unmodified
// RULE9: protocol mode enables handling, resets cleared
// RULE10: protocol mode allows rewrite and timestamps
// RULE11: protocol mode enables time-of-day clock
// RULE12: protocol mode alters tail tag format
// RULE13: bit 5 enables layer 2 detection
// RULE14: bit 4 enables IPv4 UDP detection
// RULE15: bit 3 enables IPv6 UDP detection
// RULE16: bit 2 selects peer or end transparent
// RULE17: bit 1 selects host master or slave
// RULE18: bit 0 selects one or two step
module ptp_message_config_regs
  import ptp_cfg_pkg::*;
(
  // clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // mode outputs
  output ptp_mode_type mode,
  output adjust_type adjust
);

  logic [15:0] dur_high_reg;
  logic [15:0] dur_low_reg;
  logic [7:0] cfg_reg;
  logic [15:0] rate_high_reg;
  logic [15:0] rate_low_reg;
  logic [31:0] adj_count_reg;
  logic [31:0] adj_count_next;
  adj_state_type adj_state_reg;
  logic [31:0] duration;
  logic start_pulse;
  logic stop_pulse;
  logic done;
  logic ptp_on;
  logic as_on;

  assign duration = {dur_high_reg, dur_low_reg}; // RULE1 RULE2
  assign start_pulse = reg_write && reg_addr == RATE_HIGH_OFFSET && reg_wdata[TEMP_ADJ_BIT];
  assign stop_pulse = reg_write && reg_addr == RATE_HIGH_OFFSET && !reg_wdata[TEMP_ADJ_BIT];
  assign adj_count_next = adj_count_reg + 32'h00000001;
  assign done = adj_count_next >= duration; // RULE5

  // configuration writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dur_high_reg <= DUR_RESET;
      dur_low_reg <= DUR_RESET;
      cfg_reg <= MSG_CFG_ONE_RESET; // RULE9 RULE13 RULE14 RULE15 RULE16 RULE17 RULE18
      rate_low_reg <= RATE_RESET;
    end else if (clk_en && reg_write) begin
      case (reg_addr)
        DUR_HIGH_OFFSET: dur_high_reg <= reg_wdata; // RULE2
        DUR_LOW_OFFSET: dur_low_reg <= reg_wdata; // RULE1
        MSG_CFG_ONE_OFFSET: cfg_reg <= reg_wdata[7:0];
        RATE_LOW_OFFSET: rate_low_reg <= reg_wdata;
        default: cfg_reg <= cfg_reg;
      endcase
    end
  end

  // rate high word; the temporary adjust bit clears itself when the run ends
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rate_high_reg <= RATE_RESET;
    end else if (clk_en) begin
      if (reg_write && reg_addr == RATE_HIGH_OFFSET) begin
        rate_high_reg <= reg_wdata;
      end else if (adj_state_reg == ADJ_RUN && done) begin
        rate_high_reg[TEMP_ADJ_BIT] <= 1'b0; // RULE5
      end
    end
  end

  // temporary adjustment sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      adj_state_reg <= ADJ_IDLE;
      adj_count_reg <= 32'h00000000;
    end else if (clk_en) begin
      case (adj_state_reg)
        ADJ_IDLE: begin
          adj_count_reg <= 32'h00000000;
          if (start_pulse && {dur_high_reg, dur_low_reg} != 32'h00000000) begin
            adj_state_reg <= ADJ_RUN;
          end
        end
        ADJ_RUN: begin
          if (stop_pulse || done) begin
            adj_state_reg <= ADJ_IDLE; // RULE5
            adj_count_reg <= 32'h00000000;
          end else begin
            adj_count_reg <= adj_count_next; // RULE5
          end
        end
        default: adj_state_reg <= ADJ_IDLE;
      endcase
    end
  end

  // adjustment request toward the time counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      adjust <= '0;
    end else if (clk_en) begin
      adjust.active <= adj_state_reg == ADJ_RUN && !stop_pulse && !done; // RULE3
      adjust.add <= rate_high_reg[RATE_DIR_BIT]; // RULE4
      adjust.step <= {rate_high_reg[13:0], rate_low_reg}; // RULE3
    end
  end

  assign ptp_on = cfg_reg[PTP_MODE_BIT];
  assign as_on = ptp_on && cfg_reg[AS_MODE_BIT]; // RULE6

  // decoded mode outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode <= '0;
    end else if (clk_en) begin
      mode.ptp_enable <= ptp_on; // RULE9
      mode.as_mode <= as_on; // RULE6
      mode.forward_all_to_host <= as_on; // RULE7
      mode.header_rewrite_allowed <= ptp_on && !as_on; // RULE8 RULE10
      mode.timestamp_insert <= ptp_on; // RULE10
      mode.tod_clock_enable <= ptp_on; // RULE11
      mode.timestamp_tail_tag <= ptp_on; // RULE12
      mode.detect_l2 <= cfg_reg[L2_DETECT_BIT]; // RULE13
      mode.detect_ipv4 <= cfg_reg[IPV4_DETECT_BIT]; // RULE14
      mode.detect_ipv6 <= cfg_reg[IPV6_DETECT_BIT]; // RULE15
      mode.peer_to_peer <= cfg_reg[P2P_BIT]; // RULE16
      mode.host_master <= cfg_reg[MASTER_BIT]; // RULE17
      mode.one_step <= cfg_reg[ONE_STEP_BIT]; // RULE18
    end
  end

  // read data, valid the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      if (reg_read) begin
        case (reg_addr)
          DUR_HIGH_OFFSET: reg_rdata <= dur_high_reg;
          DUR_LOW_OFFSET: reg_rdata <= dur_low_reg;
          MSG_CFG_ONE_OFFSET: reg_rdata <= {8'h00, cfg_reg};
          RATE_HIGH_OFFSET: reg_rdata <= rate_high_reg;
          RATE_LOW_OFFSET: reg_rdata <= rate_low_reg;
          default: reg_rdata <= 16'h0000;
        endcase
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

endmodule : ptp_message_config_regs

`default_nettype wire

// ### test/ptp_message_config_regs_assertions.sv
// assertions on the ports of the time protocol register bank
// assumes clk_en stays high around config writes and adjust start or stop
`timescale 1ns/100ps
`default_nettype none
module ptp_regs_checker
  import ptp_cfg_pkg::*;
(
  // clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // outputs
  input wire ptp_mode_type mode,
  input wire adjust_type adjust
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence cfg_wr;
    reg_write && clk_en && reg_addr == 12'h514 ##1 clk_en;
  endsequence
  sequence adj_stop;
    adjust.active && reg_write && clk_en && reg_addr == 12'h50C && !reg_wdata[14];
  endsequence
  as_gate_a: assert property (mode.forward_all_to_host |-> mode.ptp_enable)
    else $error("forward without protocol mode");
  hdr_keep_a: assert property (mode.forward_all_to_host |-> !mode.header_rewrite_allowed)
    else $error("header rewrite in 802.1AS mode");
  fwd_all_a: assert property (cfg_wr |=> mode.forward_all_to_host == ($past(reg_wdata[7], 2) && $past(reg_wdata[6], 2)))
    else $error("forward flag wrong");
  tod_on_a: assert property (mode.tod_clock_enable == mode.ptp_enable)
    else $error("time-of-day enable wrong");
  tail_tag_a: assert property (mode.timestamp_tail_tag == mode.ptp_enable)
    else $error("tail tag format wrong");
  ts_insert_a: assert property (mode.timestamp_insert == mode.ptp_enable)
    else $error("timestamp insert wrong");
  cfg_fields_a: assert property (cfg_wr |=> {mode.detect_l2, mode.detect_ipv4, mode.detect_ipv6, mode.peer_to_peer,
    mode.host_master, mode.one_step} == $past(reg_wdata[5:0], 2))
    else $error("config fields wrong");
  adj_start_a: assert property ($rose(adjust.active) |-> $past(reg_write, 2) && $past(reg_wdata[14], 2))
    else $error("adjust started without write");
  adj_stop_a: assert property (adj_stop |-> ##[1:2] !adjust.active)
    else $error("adjust did not stop");
endmodule : ptp_regs_checker
bind ptp_message_config_regs ptp_regs_checker chk_i (.ref_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .mode, .adjust);
`default_nettype wire

// ### test/ptp_message_config_regs_tb.sv
// self-checking bench for the time protocol register bank
// assumes the package and the design are compiled first
`timescale 1ns/100ps
`default_nettype none
module ptp_message_config_regs_tb;
  import ptp_cfg_pkg::*;
  logic ref_clk = 0, rst = 1, clk_en = 1, reg_write = 0, reg_read = 0;
  logic [11:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata;
  ptp_mode_type mode;
  adjust_type adjust;
  int err_count = 0, n_compared = 0, n_act;
  // write value, read value, expected decoded mode
  logic [41:0] rows [6] = '{{16'h0000, 16'h0000, 10'h000}, {16'h00FF, 16'h00FF, 10'h3FF},
    {16'hFFC0, 16'h00C0, 10'h3C0}, {16'h0046, 16'h0046, 10'h2C6}, {16'h00BD, 16'h00BD, 10'h03D},
    {16'h0081, 16'h0081, 10'h001}};
  wire logic [9:0] m10 = {mode.ptp_enable, mode.forward_all_to_host, mode.tod_clock_enable, mode.timestamp_tail_tag,
    mode.detect_l2, mode.detect_ipv4, mode.detect_ipv6, mode.peer_to_peer, mode.host_master, mode.one_step};
  always #10 ref_clk = ~ref_clk;
  ptp_message_config_regs uut (.ref_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .mode, .adjust);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_write <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_read <= 1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 0;
    #1 chk("rdata", {16'h0000, e}, {16'h0000, reg_rdata});
    @(posedge ref_clk);
    #1 chk("rdata_idle", 0, {16'h0000, reg_rdata});
  endtask : rd
  task automatic print_verdict;
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    rd(12'h514, 16'h0039);
    rd(12'h512, 16'h0000);
    rd(12'h516, 16'h0000);
    foreach (rows[i]) begin
      wr(12'h514, rows[i][41:26]);
      rd(12'h514, rows[i][25:10]);
      chk("mode", {22'h0, rows[i][9:0]}, {22'h0, m10});
    end
    @(posedge ref_clk);
    clk_en <= 0;
    wr(12'h514, 16'h0000);
    clk_en <= 1;
    rd(12'h514, 16'h0081);
    wr(12'h510, 16'hA5A5);
    rd(12'h510, 16'hA5A5);
    wr(12'h510, 16'h0000);
    wr(12'h512, 16'h0005);
    rd(12'h512, 16'h0005);
    wr(12'h50E, 16'h1234);
    wr(12'h50C, 16'hC005);
    n_act = 0;
    repeat (10) begin
      @(posedge ref_clk);
      #1 n_act += adjust.active;
      if (adjust.active) chk("step", {1'b0, 1'b1, 30'h00051234}, {1'b0, adjust.add, adjust.step});
    end
    chk("cycles", 1, (n_act >= 3 && n_act <= 4));
    rd(12'h50C, 16'h8005);
    wr(12'h512, 16'h0064);
    wr(12'h50C, 16'h4007);
    repeat (4) @(posedge ref_clk);
    #1 chk("active", 2'b10, {adjust.active, adjust.add});
    wr(12'h50C, 16'h0000);
    repeat (2) @(posedge ref_clk);
    #1 chk("stopped", 0, adjust.active);
    @(posedge ref_clk);
    rst <= 1;
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    rd(12'h514, 16'h0039);
    chk("mode_rst", {22'h0, 10'h039}, {22'h0, m10});
    print_verdict();
  end
endmodule : ptp_message_config_regs_tb
`default_nettype wire
